// File: rtl/ccp_compare_pkg.sv
// constants and types shared by the compare unit
package ccp_compare_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   localparam int TMR_W = 16;
   // register indices on the plain port
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_VALUE_LOW = 4'h1;
   localparam logic [3:0] ADDR_VALUE_HIGH = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_MASK = 4'h4;
   localparam logic [3:0] ADDR_TIMER_LOW = 4'h5;
   localparam logic [3:0] ADDR_TIMER_HIGH = 4'h6;
   // control register fields
   localparam int CTL_EN_BIT = 7;
   localparam int CTL_TRIG_SEL_BIT = 6;
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_MODE_W = 2;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // status and mask bits
   localparam int ST_MATCH_BIT = 0;
   localparam int ST_TRIG_BIT = 1;
   localparam int ST_W = 2;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [15:0] ONE_WORD = 16'h0001;
   // output action taken at a match
   typedef enum logic [1:0] {
      MODE_TOGGLE,
      MODE_SET,
      MODE_CLEAR,
      MODE_PULSE
   } out_mode_t;
   typedef enum {
      RST_IDLE,
      RST_PENDING
   } reset_state_t;
endpackage

// File: rtl/ccp_compare_if.sv
// signals between the register side and the match engine, in both directions
`timescale 1ns/1ps
interface ccp_compare_if;
   logic enable;
   logic [15:0] compare_value;
   logic [15:0] timer_value;
   logic timer_tick;
   logic match;
   modport regs (output enable, output compare_value, input timer_value,
      input timer_tick, input match);
   modport engine (input enable, input compare_value, output timer_value,
      input timer_tick, output match);
endinterface

// File: rtl/ccp_compare_match.sv
// base timer counter and equality detector
`timescale 1ns/1ps
module ccp_compare_match
   import ccp_compare_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic timer_clear_i,
   ccp_compare_if.engine bus
);
   logic [15:0] count;

   always_ff @(posedge clk_i) begin
      if (rst_i || timer_clear_i) begin
         count <= ZERO_WORD;
      end else if (bus.timer_tick) begin
         count <= count + ONE_WORD;
      end
   end

   // equality seen on each tick, while the unit is enabled
   assign bus.match = bus.enable && bus.timer_tick &&
      (count == bus.compare_value);
   assign bus.timer_value = count;
endmodule

// File: rtl/ccp_compare_unit.sv
// compare unit: registers, output latch, trigger and timer reset
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
module ccp_compare_unit
   import ccp_compare_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ccp_compare_pkg::ADDR_W-1:0] addr_i,
   input wire logic [ccp_compare_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [ccp_compare_pkg::DATA_W-1:0] rdata_o,
   input wire logic timer_tick_i,
   input wire logic ext_clk_i,
   input wire logic ext_clk_sel_i,
   input wire logic sleep_i,
   output logic compare_out_o,
   output logic compare_pin_o,
   output logic conv_trigger_o,
   output logic wake_o,
   output logic irq_o
);
   import ccp_compare_pkg::*;

   ccp_compare_if link ();

   logic [7:0] compare_control_reg;
   logic [7:0] compare_value_low;
   logic [7:0] compare_value_high;
   logic [ST_W-1:0] status;
   logic [ST_W-1:0] mask;
   logic compare_event_flag;
   logic out_latch;
   logic ext_sync1;
   logic ext_sync2;
   logic ext_prev;
   logic ext_tick;
   logic trig_pend;
   logic [15:0] match_value;
   logic timer_clear;
   reset_state_t rst_state;
   out_mode_t mode;
   logic ctl_wr;
   logic status_rd;

   assign ctl_wr = wr_i && (addr_i == ADDR_CONTROL);
   assign status_rd = rd_i && (addr_i == ADDR_STATUS);
   assign mode = out_mode_t'(compare_control_reg[CTL_MODE_LSB +: CTL_MODE_W]);

   // external timer clock synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_sync1 <= 1'b0;
         ext_sync2 <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         ext_sync1 <= ext_clk_i;
         ext_sync2 <= ext_sync1;
         ext_prev <= ext_sync2;
      end
   end

   // timer advances synchronously from either tick source
   assign ext_tick = ext_sync2 && !ext_prev;
   assign link.timer_tick = ext_clk_sel_i ? ext_tick : timer_tick_i;
   assign link.enable = compare_control_reg[CTL_EN_BIT];
   assign link.compare_value = {compare_value_high, compare_value_low};

   ccp_compare_match engine (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .timer_clear_i(timer_clear),
      .bus(link.engine)
   );

   // register writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_control_reg <= CONTROL_RESET;
         compare_value_low <= ZERO_BYTE;
         compare_value_high <= ZERO_BYTE;
         mask <= '0;
      end else if (wr_i) begin
         case (addr_i)
            ADDR_CONTROL: compare_control_reg <= wdata_i;
            ADDR_VALUE_LOW: compare_value_low <= wdata_i;
            ADDR_VALUE_HIGH: compare_value_high <= wdata_i;
            ADDR_MASK: mask <= wdata_i[ST_W-1:0];
            default: ;
         endcase
      end
   end

   // output latch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_latch <= 1'b0;
      end else if (ctl_wr && (wdata_i == CONTROL_RESET)) begin
         out_latch <= 1'b0;
      end else if (link.match) begin
         case (mode)
            MODE_TOGGLE: out_latch <= !out_latch;
            MODE_SET: out_latch <= 1'b1;
            MODE_CLEAR: out_latch <= 1'b0;
            MODE_PULSE: out_latch <= 1'b1;
            default: out_latch <= out_latch;
         endcase
      end else if (mode == MODE_PULSE) begin
         out_latch <= 1'b0;
      end
   end

   // event flag follows any match until read
   assign compare_event_flag = status[ST_MATCH_BIT];

   // sticky status, set wins over read clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= '0;
      end else begin
         status[ST_MATCH_BIT] <= link.match ||
            (status[ST_MATCH_BIT] && !status_rd);
         status[ST_TRIG_BIT] <= (link.match && compare_control_reg[CTL_TRIG_SEL_BIT]) ||
            (status[ST_TRIG_BIT] && !status_rd);
      end
   end

   // trigger pulse on the match, timer reset at the following edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_trigger_o <= 1'b0;
      end else begin
         conv_trigger_o <= link.match && compare_control_reg[CTL_TRIG_SEL_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_state <= RST_IDLE;
         trig_pend <= 1'b0;
         match_value <= ZERO_WORD;
      end else begin
         case (rst_state)
            RST_IDLE: begin
               if (link.match && compare_control_reg[CTL_TRIG_SEL_BIT]) begin
                  rst_state <= RST_PENDING;
                  trig_pend <= 1'b1;
                  match_value <= link.compare_value;
               end
            end
            RST_PENDING: begin
               rst_state <= RST_IDLE;
               trig_pend <= 1'b0;
            end
            default: begin
               rst_state <= RST_IDLE;
               trig_pend <= 1'b0;
            end
         endcase
      end
   end

   // timer already stepped past the match; reset only if the pair is unchanged
   assign timer_clear = trig_pend &&
      (match_value == link.compare_value);

   // read port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= ZERO_BYTE;
      end else if (rd_i) begin
         case (addr_i)
            ADDR_CONTROL: rdata_o <= compare_control_reg;
            ADDR_VALUE_LOW: rdata_o <= compare_value_low;
            ADDR_VALUE_HIGH: rdata_o <= compare_value_high;
            ADDR_STATUS: rdata_o <= {{(DATA_W-ST_W){1'b0}}, status};
            ADDR_MASK: rdata_o <= {{(DATA_W-ST_W){1'b0}}, mask};
            ADDR_TIMER_LOW: rdata_o <= link.timer_value[7:0];
            ADDR_TIMER_HIGH: rdata_o <= link.timer_value[15:8];
            default: rdata_o <= ZERO_BYTE;
         endcase
      end else begin
         rdata_o <= ZERO_BYTE;
      end
   end

   assign compare_out_o = out_latch;
   assign compare_pin_o = out_latch;
   assign irq_o = |(status & mask);
   // wake needs sleep, the held event flag and its mask bit; no running timer is needed
   assign wake_o = sleep_i && compare_event_flag && mask[ST_MATCH_BIT];
endmodule

// File: tb/ccp_compare_checker.sv
// port assertions for the compare unit
`timescale 1ns/1ps
module ccp_compare_checker
   import ccp_compare_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic timer_tick_i,
   input wire logic ext_clk_sel_i,
   input wire logic sleep_i,
   input wire logic compare_out_o,
   input wire logic compare_pin_o,
   input wire logic conv_trigger_o,
   input wire logic wake_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   pin_mirror_a: assert property (compare_pin_o == compare_out_o)
      else $error("pin and internal output differ");
   ctl_clear_a: assert property (wr_i && addr_i == ADDR_CONTROL && wdata_i == ZERO_BYTE
      |-> ##2 !compare_out_o) else $error("latch not low after control clear");
   trig_pulse_a: assert property (conv_trigger_o |=> !conv_trigger_o)
      else $error("trigger longer than one cycle");
   trig_tick_a: assert property (conv_trigger_o |-> $past(timer_tick_i) || $past(ext_clk_sel_i))
      else $error("trigger without a timer tick");
   wake_sleep_a: assert property (wake_o |-> sleep_i && irq_o)
      else $error("wake without sleep or event");
   irq_hold_a: assert property ($fell(irq_o) |-> $past(rd_i) || $past(wr_i))
      else $error("event flag dropped without access");
   flag_read_a: assert property (rd_i && addr_i == ADDR_STATUS && irq_o
      |=> rdata_o != ZERO_BYTE) else $error("status read empty while irq high");
   out_steady_a: assert property ($changed(compare_out_o)
      |-> $past(timer_tick_i) || $past(ext_clk_sel_i) || $past(wr_i))
      else $error("latch moved without cause");
endmodule
bind ccp_compare_unit ccp_compare_checker chk_i (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .timer_tick_i, .ext_clk_sel_i, .sleep_i, .compare_out_o,
   .compare_pin_o, .conv_trigger_o, .wake_o, .irq_o);

// File: tb/ccp_far_model.sv
// timer tick source and converter trigger counter
`timescale 1ns/1ps
module ccp_far_model (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic one_i,
   input wire logic conv_trigger_i,
   output logic timer_tick_o,
   output int trig_count_o
);
   logic [1:0] div = 2'h0;
   initial trig_count_o = 0;
   // synchronous ticks at a quarter of the clock while run, plus single ticks from one_i, never asynchronous
   assign timer_tick_o = (run_i && div == 2'h3) || one_i;
   always @(posedge clk_i) begin
      div <= div + 2'h1;
      if (conv_trigger_i) trig_count_o <= trig_count_o + 1;
   end
endmodule

// File: tb/ccp_compare_unit_tb.sv
// self-checking bench for the compare unit
`timescale 1ns/1ps
module ccp_compare_unit_tb;
   import ccp_compare_pkg::*;
   logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sleep_i = 0, run = 0, one = 0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o;
   logic tick, out_o, pin_o, trig_o, wake_o, irq_o;
   int n_mismatch = 0, compares = 0, n_trig, i;
   always #2 clk_i = ~clk_i;
   ccp_far_model far (.clk_i, .run_i(run), .one_i(one), .conv_trigger_i(trig_o),
      .timer_tick_o(tick), .trig_count_o(n_trig));
   ccp_compare_unit uut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .timer_tick_i(tick), .ext_clk_i(1'h0), .ext_clk_sel_i(1'h0), .sleep_i,
      .compare_out_o(out_o), .compare_pin_o(pin_o), .conv_trigger_o(trig_o), .wake_o, .irq_o);
   task automatic end_sim();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // optional same-cycle tick beside the write
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic t = 1'h0);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1;
      one <= t;
      @(posedge clk_i);
      wr_i <= 0;
      one <= 0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1;
      @(posedge clk_i);
      rd_i <= 0;
      @(negedge clk_i);
      chk(rdata_o, exp);
   endtask
   task automatic wait_trig();
      @(negedge clk_i);
      for (i = 0; i < 200 && trig_o !== 1'h1; i++) @(negedge clk_i);
      if (i == 200) begin
         n_mismatch++;
         end_sim();
      end
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      wr(ADDR_VALUE_LOW, 8'h03);
      wr(ADDR_VALUE_HIGH, 8'h00);
      wr(ADDR_MASK, 8'h03);
      wr(ADDR_CONTROL, 8'hC1);
      repeat (3) wr(ADDR_TIMER_LOW, 8'h00, 1'h1);
      rd(ADDR_TIMER_LOW, 8'h03);
      wr(ADDR_TIMER_LOW, 8'h00, 1'h1);
      @(negedge clk_i);
      chk({4'h0, out_o, pin_o, trig_o, irq_o}, 8'h0F);
      rd(ADDR_TIMER_LOW, 8'h00);
      rd(ADDR_TIMER_HIGH, 8'h00);
      rd(ADDR_STATUS, 8'h03);
      rd(ADDR_STATUS, 8'h00);
      chk({7'h0, irq_o}, 8'h00);
      wr(ADDR_VALUE_LOW, 8'h02);
      wr(ADDR_CONTROL, 8'hC0);
      @(posedge clk_i);
      run <= 1;
      wait_trig();
      chk({7'h0, out_o}, 8'h00);
      wait_trig();
      chk({7'h0, out_o}, 8'h01);
      @(posedge clk_i);
      run <= 0;
      @(negedge clk_i);
      chk(n_trig[7:0], 8'h03);
      wr(ADDR_CONTROL, 8'h00);
      @(posedge clk_i);
      @(negedge clk_i);
      chk({7'h0, out_o}, 8'h00);
      @(posedge clk_i);
      rst_i <= 1;
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_CONTROL, 8'hC1);
      wr(ADDR_VALUE_LOW, 8'h07, 1'h1);
      @(negedge clk_i);
      chk({6'h0, out_o, trig_o}, 8'h03);
      @(posedge clk_i);
      sleep_i <= 1;
      @(negedge clk_i);
      chk({7'h0, wake_o}, 8'h01);
      @(posedge clk_i);
      sleep_i <= 0;
      rd(ADDR_TIMER_LOW, 8'h01);
      rd(ADDR_STATUS, 8'h03);
      end_sim();
   end
endmodule
